// [logic/pfm_pkg.sv]
package pfm_pkg;
    localparam int NUM_CH          = 4;
    localparam int CLK_HZ          = 200_000_000;
    localparam int BLANK_TIME_US   = 60;
    localparam int FILTER_TIME_US  = 10;
    localparam int RETRY_PERIOD_MS = 10;
    localparam int RETRY_PULSE_US  = 68;
    localparam int BLANK_CYC       = BLANK_TIME_US * (CLK_HZ / 1_000_000);
    localparam int FILTER_CYC      = FILTER_TIME_US * (CLK_HZ / 1_000_000);
    localparam int RETRY_PERIOD_CYC = RETRY_PERIOD_MS * (CLK_HZ / 1_000);
    localparam int RETRY_PULSE_CYC = RETRY_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W           = 22;
    localparam logic [3:0] FAULT_WORD_RST = 4'h0;

    // Variant selection
    typedef enum logic {PFM_SHUTDOWN, PFM_RETRY} pfm_variant_e;

    // Per-channel comparator inputs
    typedef struct packed {
        logic [NUM_CH-1:0] above_int;
        logic [NUM_CH-1:0] above_ext;
    } pfm_cmp_s;

    // Battery monitor inputs
    typedef struct packed {
        logic over_v;
        logic under_v;
    } pfm_bat_s;
endpackage

// [logic/pfm_monitor.sv]
`timescale 1ns/1ps
module pfm_monitor
    import pfm_pkg::*;
#(
    parameter pfm_variant_e VARIANT  = PFM_SHUTDOWN,
    parameter bit           HAS_UVLO = 1'b1,
    parameter int           RETRY_PERIOD = RETRY_PERIOD_CYC
)(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // Controller side
    input  wire logic [NUM_CH-1:0] serial_ctrl,
    input  wire logic [NUM_CH-1:0] parallel_in,
    input  wire logic              cs_fall,
    // Analog monitors, already synchronised
    input  wire pfm_cmp_s          cmp,
    input  wire pfm_bat_s          bat,
    input  wire logic              ext_ref_select,
    // Outputs
    output logic      [NUM_CH-1:0] gate_drive,
    output logic      [NUM_CH-1:0] fault_word,
    output logic                   fault_flag_n
);
    logic rst_s1_q;
    logic rst_b_q;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_q <= 1'b0;
            rst_b_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_b_q  <= rst_s1_q;
        end
    end

    // Reference selection and battery state
    wire [NUM_CH-1:0] drain_sense = ext_ref_select ? cmp.above_ext : cmp.above_int;
    wire bat_fault = bat.over_v | (HAS_UVLO & bat.under_v);
    wire [NUM_CH-1:0] cmd_on = serial_ctrl | parallel_in;

    // Per-channel results; nets, because each bit is driven by its own channel instance
    wire  [NUM_CH-1:0] load_fault;
    wire  [NUM_CH-1:0] gate_d;

    // Output registers; the pins only ever show flop outputs
    logic [NUM_CH-1:0] gate_drive_q;
    logic [NUM_CH-1:0] fault_word_q;
    logic              flag_q;

    // Shared retry timebase; one timer serves all channels to save area.
    // Limitation: channels in retry pulse in step, not from their own fault time.
    logic [CNT_W-1:0] retry_cnt_q;
    wire              retry_wrap = (retry_cnt_q == CNT_W'(RETRY_PERIOD - 1));
    wire              retry_on   = (retry_cnt_q < CNT_W'(RETRY_PULSE_CYC));
    always_ff @(posedge mclk or negedge rst_b_q)
    begin
        if (!rst_b_q)
            retry_cnt_q <= '0;
        else
            retry_cnt_q <= retry_wrap ? '0 : retry_cnt_q + 1'b1;
    end

    // Per-channel supervision, one instance per output channel
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        pfm_chan #(
            .VARIANT (VARIANT)
        ) u_chan (
            .mclk        (mclk),
            .rst_sync_b  (rst_b_q),
            .cmd_on      (cmd_on[i]),
            .retry_on    (retry_on),
            .bat_fault   (bat_fault),
            .drain_sense (drain_sense[i]),
            .gate_req    (gate_d[i]),
            .load_fault  (load_fault[i])
        );
    end

    // Any standing fault; battery faults reach the flag but never the word
    wire              any_fault = bat_fault | (|load_fault);
    // A new fault wins over the release on chip select, so none is lost
    wire              flag_d    = any_fault ? 1'b1 : (cs_fall ? 1'b0 : flag_q);
    // Live status is sampled only at the chip select fall; faults gone by then are lost
    wire [NUM_CH-1:0] word_d    = cs_fall ? load_fault : fault_word_q;

    // Gate pins are registered so an input glitch never reaches the external switch
    always_ff @(posedge mclk or negedge rst_b_q)
    begin
        if (!rst_b_q)
            gate_drive_q <= '0;
        else
            gate_drive_q <= gate_d;
    end

    // Captured fault word, held between chip select falls
    always_ff @(posedge mclk or negedge rst_b_q)
    begin
        if (!rst_b_q)
            fault_word_q <= FAULT_WORD_RST;
        else
            fault_word_q <= word_d;
    end

    // Fault flag state; the pin is active low
    always_ff @(posedge mclk or negedge rst_b_q)
    begin
        if (!rst_b_q)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    // Output pins
    assign gate_drive   = gate_drive_q;
    assign fault_word   = fault_word_q;
    assign fault_flag_n = ~flag_q;
endmodule

// One channel: blanking timer, short filter, short latch and open-load check
module pfm_chan
    import pfm_pkg::*;
#(
    parameter pfm_variant_e VARIANT = PFM_SHUTDOWN
)(
    // Clock and synchronised reset
    input  wire logic mclk,
    input  wire logic rst_sync_b,
    // Command, shared retry window and battery state
    input  wire logic cmd_on,
    input  wire logic retry_on,
    input  wire logic bat_fault,
    // Drain comparator after reference selection
    input  wire logic drain_sense,
    // Gate request and reported load fault
    output logic      gate_req,
    output logic      load_fault
);
    logic             prev_gate_q;
    logic [CNT_W-1:0] blank_q;
    logic [CNT_W-1:0] blank_d;
    logic [CNT_W-1:0] filt_q;
    logic [CNT_W-1:0] filt_d;
    logic             short_q;
    logic             short_d;

    // Gate edges; the reset value matches the idle gate so reset makes no false edge
    wire rise       = gate_req & ~prev_gate_q;
    wire fall       = ~gate_req & prev_gate_q;
    wire blank      = (blank_q != '0);

    // Comparator is only trusted once the drain has settled after a gate edge
    wire short_now  = gate_req & ~blank & drain_sense;
    wire open_now   = ~gate_req & ~blank & ~drain_sense;
    wire short_gone = gate_req & ~blank & ~drain_sense;
    wire filt_done  = (filt_q == CNT_W'(FILTER_CYC - 1));

    // Shutdown: command low clears the latch; the next high re-arms the gate
    wire clr_shutdown = (VARIANT == PFM_SHUTDOWN) & ~cmd_on;
    // Retry: command low, or drain back low during an unblanked retry pulse
    wire clr_retry    = (VARIANT == PFM_RETRY) & (~cmd_on | short_gone);
    // A retry pulse must see the comparator too, so blanking restarts on each pulse
    wire retry_ok     = (VARIANT == PFM_RETRY) & retry_on;

    // Gate request and reported fault
    assign gate_req   = cmd_on & ~bat_fault & (~short_q | retry_ok);
    assign load_fault = ~bat_fault & (short_q | open_now);

    // Blanking reloads on either gate edge, then counts down to zero
    assign blank_d = (rise | fall) ? CNT_W'(BLANK_CYC) :
                     (blank ? blank_q - 1'b1 : blank_q);
    // Filter restarts on any cycle with the drain low; it saturates at the limit
    assign filt_d  = short_now ? (filt_done ? filt_q : filt_q + 1'b1) : '0;
    // Setting the latch wins over any clear in the same cycle
    assign short_d = (short_now & filt_done) | (short_q & ~(clr_shutdown | clr_retry));

    // Channel state; all next values are worked out above
    always_ff @(posedge mclk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            prev_gate_q <= 1'b0;
            blank_q     <= '0;
            filt_q      <= '0;
            short_q     <= 1'b0;
        end
        else
        begin
            prev_gate_q <= gate_req;
            blank_q     <= blank_d;
            filt_q      <= filt_d;
            short_q     <= short_d;
        end
    end
endmodule

// [verif/pfm_chk_monitor.sv]
`timescale 1ns/1ps
module pfm_chk
    import pfm_pkg::*;
(
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rst_b,
    // Controller side
    input wire logic              cs_fall,
    input wire logic              ext_ref_select,
    input wire logic [NUM_CH-1:0] serial_ctrl,
    input wire logic [NUM_CH-1:0] parallel_in,
    // Outputs
    input wire logic              fault_flag_n,
    input wire logic [NUM_CH-1:0] gate_drive,
    input wire logic [NUM_CH-1:0] fault_word,
    // Monitors
    input wire pfm_cmp_s          cmp,
    input wire pfm_bat_s          bat
);
    // Command and battery summaries
    wire [NUM_CH-1:0] cmd = serial_ctrl | parallel_in;
    wire              bf  = bat.over_v | bat.under_v;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ov_gate_off_a: assert property (bat.over_v |=> gate_drive == 4'h0)
        else $error("gate on in overvoltage");
    uv_gate_off_a: assert property (bat.under_v |=> gate_drive == 4'h0)
        else $error("gate on in undervoltage");
    gate_needs_cmd_a: assert property ((gate_drive & ~$past(cmd)) == 4'h0)
        else $error("gate on without command");
    gate_follows_a: assert property ($past(cmd) == 4'h0 && cmd == 4'hf && !bf
        |=> gate_drive == 4'hf) else $error("gate missed command");
    word_hold_a: assert property (!cs_fall |=> $stable(fault_word))
        else $error("fault word moved without capture");
    bat_no_word_a: assert property (bf [*3] ##0 cs_fall |=> fault_word == 4'h0)
        else $error("load fault reported in battery fault");
    bat_flag_a: assert property (bf ##1 bf |-> !fault_flag_n)
        else $error("battery fault not flagged");
    flag_hold_a: assert property (!fault_flag_n && !cs_fall |=> !fault_flag_n)
        else $error("flag released without capture");
    // Main scenarios
    cover property (cs_fall ##1 fault_word != 4'h0);
    cover property (bf ##1 bf);
    cover property ($fell(gate_drive[0]));
endmodule
bind pfm_monitor pfm_chk u_chk (.*);

// [verif/pfm_host_model.sv]
`timescale 1ns/1ps
module pfm_host_model (
    // Clock, reset, read request and chip select fall pulse
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic rd_req,
    output logic      cs_fall
);
    logic [2:0] boot_q;
    // One read after power-up drops any stale undervoltage report
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b) boot_q <= 3'h0;
        else if (boot_q != 3'h7) boot_q <= boot_q + 3'h1;
    assign cs_fall = rd_req | (boot_q == 3'h3);
endmodule

// [verif/pfm_monitor_tb.sv]
`timescale 1ns/1ps
module pfm_monitor_tb
    import pfm_pkg::*;
;
    logic              mclk = 1'b0, rst_b = 1'b0, rd_req = 1'b0, sel = 1'b0, cs_fall, flag_n;
    logic [NUM_CH-1:0] ser = 4'h0, par = 4'h0, shrt = 4'h0, opn = 4'h0, gate, word, drn;
    logic [NUM_CH-1:0] gate_r, word_r, drn_r;
    logic              flag_r;
    pfm_cmp_s          cmp = '0;
    pfm_cmp_s          cmp_r = '0;
    int                cnt;
    localparam int     RTY_PERIOD = 16000;
    pfm_bat_s          bat = '0;
    int                bad_count = 0, tests_run = 0, ch;
    // Drain is the inverse of its gate unless a fault is injected; the unused reference reads inverted
    always #2.5 mclk = ~mclk;
    assign drn = shrt | ~(gate | opn);
    always @(posedge mclk) cmp <= sel ? {~drn, drn} : {drn, ~drn};
    assign drn_r = shrt | ~(gate_r | opn);
    always @(posedge mclk) cmp_r <= sel ? {~drn_r, drn_r} : {drn_r, ~drn_r};
    pfm_monitor DUT (.mclk(mclk), .rst_b(rst_b), .serial_ctrl(ser), .parallel_in(par),
        .cs_fall(cs_fall), .cmp(cmp), .bat(bat), .ext_ref_select(sel), .gate_drive(gate),
        .fault_word(word), .fault_flag_n(flag_n));
    pfm_host_model HOST (.mclk(mclk), .rst_b(rst_b), .rd_req(rd_req), .cs_fall(cs_fall));
    // Retry variant with a short period so a whole pulse train fits the run
    pfm_monitor #(.VARIANT(PFM_RETRY), .HAS_UVLO(1'b1), .RETRY_PERIOD(RTY_PERIOD)) DUT_RETRY (
        .mclk(mclk), .rst_b(rst_b), .serial_ctrl(ser), .parallel_in(par),
        .cs_fall(cs_fall), .cmp(cmp_r), .bat(bat), .ext_ref_select(sel), .gate_drive(gate_r),
        .fault_word(word_r), .fault_flag_n(flag_r));
    // Outputs are read at the edge, before that edge's updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        tests_run++;
        if (got !== exp) $display("mismatch at %0t got %h exp %h", $time, got, exp);
        if (got !== exp) bad_count++;
    endtask
    task automatic chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp) $display("mismatch at %0t got %h exp %h", $time, got, exp);
        if (got != exp) bad_count++;
    endtask
    // Cycles in a window in which the retry gate of the channel under test is on
    task automatic count_on(input int n, output int c);
        c = 0;
        repeat (n)
        begin
            @(posedge mclk);
            if (gate_r[ch] === 1'b1) c++;
        end
    endtask
    // Gates follow either command and drop while a battery fault stands
    function automatic logic [4:0] exp_gate(input logic [3:0] s, input logic [3:0] p,
                                            input pfm_bat_s b);
        return {1'b0, (s | p) & {4{~(b.over_v | b.under_v)}}};
    endfunction
    task automatic rd;
        rd_req <= 1'b1;
        cyc(1);
        rd_req <= 1'b0;
        cyc(2);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Random commands and battery faults, then a short and an open load on one channel
    initial
    begin
        void'($urandom(77770));
        cyc(4);
        rst_b <= 1'b1;
        cyc(8);
        par <= 4'hf;
        cyc(3);
        chk({1'b0, gate}, 5'h0f);
        repeat (30)
        begin
            {sel, ser, par} <= 9'($urandom);
            bat <= ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
            cyc(3);
            chk({1'b0, gate}, exp_gate(ser, par, bat));
            chk({1'b0, gate_r}, exp_gate(ser, par, bat));
            rd();
            chk({word, flag_n}, {4'h0, ~|bat});
        end
        $display("test random commands done");
        {ser, par, bat} <= '0;
        ch = $urandom % 4;
        cyc(3);
        rd();
        par[ch] <= 1'b1;
        shrt[ch] <= 1'b1;
        cyc(BLANK_CYC - 100);
        chk({4'h0, flag_n}, 5'h01);
        cyc(FILTER_CYC);
        chk({4'h0, flag_n}, 5'h01);
        cyc(300);
        rd();
        chk({word, flag_n}, {4'h1 << ch, 1'b0});
        chk({word_r, flag_r}, {4'h1 << ch, 1'b0});
        count_on(RTY_PERIOD, cnt);
        chk_cnt(cnt, RETRY_PULSE_CYC);
        shrt[ch] <= 1'b0;
        cyc(20);
        chk({1'b0, gate}, 5'h00);
        cyc(RTY_PERIOD + BLANK_CYC + 100);
        count_on(3000, cnt);
        chk_cnt(cnt, 3000);
        rd();
        chk({word_r, flag_r}, 5'h01);
        par[ch] <= 1'b0;
        cyc(3);
        par[ch] <= 1'b1;
        cyc(3);
        rd();
        chk({gate, flag_n}, {4'h1 << ch, 1'b1});
        $display("test short load done");
        par <= 4'h0;
        opn[ch] <= 1'b1;
        cyc(BLANK_CYC - 100);
        chk({word, flag_n}, 5'h01);
        cyc(300);
        chk({4'h0, flag_n}, 5'h00);
        bat.over_v <= 1'b1;
        cyc(3);
        rd();
        chk({word, flag_n}, 5'h00);
        bat.over_v <= 1'b0;
        cyc(3);
        rd();
        chk({word, flag_n}, {4'h1 << ch, 1'b0});
        opn[ch] <= 1'b0;
        cyc(3);
        rd();
        chk({word, flag_n}, 5'h01);
        $display("test open load done");
        stop_test();
    end
endmodule
